// [bench/twowire_slave_pointer_hyst_tb.sv]
/*
  Self-checking bench: APB drives the master, which talks to the slave.
  Assumes the master acknowledges APB with zero wait and sets a busy flag.
*/
`include "tws_consts.svh"
`default_nettype none
module twowire_slave_pointer_hyst_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] ADDR = `TWS_SLAVE_ADDR;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr; // Error response, never expected here.
  logic [7:0] hyst;
  logic [7:0] ptr;
  logic hs;
  logic hs_seen = 1'b0; // Remembers that high-speed mode was entered.
  int n_fail = 0;
  int comparisons = 0;
  logic [31:0] seed = 32'h89a06b10;
  logic [7:0] mhyst = `TWS_HYST_RESET; // Expected register content.
  logic [7:0] p; // Pointer chosen for the unmapped case.
  logic [31:0] st; // Last status word.

  always #5 clk = ~clk;
  // A short half period keeps the run brief; the slave still syncs safely.
  tws_if tws_if_i ();
  tws_slave tws_slave_i (.clk(clk), .rst_n(rst_n), .bus(tws_if_i),
    .hyst_value_bits(hyst), .ptr_value(ptr), .hs_mode(hs));
  tws_master #(.HALF_CYCLES(20)) tws_master_i (.clk(clk), .rst_n(rst_n), .bus(tws_if_i),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  tws_monitor tws_monitor_i (.clk(clk), .rst_n(rst_n), .scl_oe_m(tws_if_i.scl_oe_m),
    .sda_oe_m(tws_if_i.sda_oe_m), .sda_oe_s(tws_if_i.sda_oe_s), .scl(tws_if_i.scl),
    .sda(tws_if_i.sda));

  // The mode flag is a pulse between the code byte and stop, so latch it.
  always @(posedge clk) begin
    if (hs === 1'b1) begin
      hs_seen <= 1'b1;
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // Only the hysteresis pointer is mapped here; others read as zero.
  function automatic logic [7:0] exp_rd(input logic [7:0] pt, input logic [7:0] h);
    return (pt == `TWS_PTR_HYST) ? h : 8'h00;
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // No wait count is assumed; only the watchdog ends a hung access.
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // A whole link transaction, waiting on the busy flag with a bound.
  task automatic xfer(input logic [6:0] a, input logic [7:0] pt, input logic [7:0] d,
    input logic [2:0] cmd);
    int k;
    apb(1'b1, `TWS_ADDR_WDATA, {9'h0, a, pt, d}, st);
    apb(1'b1, `TWS_ADDR_APB, {29'h0, cmd}, st);
    k = 0;
    do begin
      apb(1'b0, `TWS_ADDR_STAT, 32'h0, st);
      k++;
    end while (st[0] !== 1'b0 && k < 2000);
    if (k >= 2000) begin
      n_fail++;
      close_out;
    end
    // Let the slave's synchronisers see the stop before anything is compared.
    repeat (4) @(posedge clk);
  endtask

  task automatic rd_chk(input logic [7:0] exp);
    logic [31:0] q;
    xfer(ADDR, 8'h00, 8'h00, 3'b011);
    apb(1'b0, `TWS_ADDR_RDATA, 32'h0, q);
    chk(q[7:0], exp);
    chk({7'h0, pslverr}, 8'h00);
  endtask

  task automatic close_out;
    $display("mismatches %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #900000;
    n_fail++;
    close_out;
  end

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(hyst, 8'h0a);
    chk(ptr, `TWS_PTR_RESET);
    xfer(ADDR, `TWS_PTR_HYST, 8'h00, 3'b101);
    chk(ptr, 8'h21);
    chk(hyst, 8'h0a);
    rd_chk(8'h0a);
    // Extremes first, then random values, each written and read twice.
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      mhyst = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : seed[7:0];
      xfer(ADDR, `TWS_PTR_HYST, mhyst, 3'b001);
      chk(hyst, mhyst);
      chk({7'h0, st[1]}, 8'h00);
      rd_chk(exp_rd(8'h21, mhyst));
      rd_chk(exp_rd(8'h21, mhyst));
    end
    // A write to an unmapped pointer moves the pointer only.
    p = (seed[15:8] == 8'h21) ? 8'h22 : seed[15:8];
    xfer(ADDR, p, ~mhyst, 3'b001);
    chk(ptr, p);
    chk(hyst, mhyst);
    rd_chk(exp_rd(p, mhyst));
    // A foreign address is refused and changes nothing.
    xfer(ADDR + 7'h01, 8'h21, 8'h55, 3'b001);
    chk({7'h0, st[1]}, 8'h01);
    chk(ptr, p);
    chk(hyst, mhyst);
    // The high-speed code is refused yet switches the mode until stop.
    xfer(7'h05, 8'h21, 8'h66, 3'b001);
    chk({7'h0, st[1]}, 8'h01);
    chk({7'h0, hs_seen}, 8'h01);
    chk({7'h0, hs}, 8'h00);
    xfer(ADDR, `TWS_PTR_HYST, 8'h00, 3'b101);
    rd_chk(mhyst);
    close_out;
  end
endmodule // twowire_slave_pointer_hyst_tb
`default_nettype wire

// [bench/tws_monitor.sv]
/*
  Checker on the two-wire carrier lines between master and slave.
  Assumes the lines are sampled on the system clock that paces the master.
*/
`include "tws_consts.svh"
`default_nettype none
module tws_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_oe_m,
  input wire logic sda_oe_m,
  input wire logic sda_oe_s,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q_r; // Clock level one cycle ago.
  logic sda_q_r; // Data level one cycle ago.
  logic [3:0] cnt_r; // Bit number inside the byte, 1 to 9.
  logic [3:0] byte_r; // Byte index since the last start.
  logic [7:0] sh_r; // Bits taken at clock rises.
  logic ign_r; // Address missed, so the slave must stay quiet.
  logic rd_r; // Direction bit of the current transfer.
  wire logic start_w = scl && scl_q_r && sda_q_r && !sda;
  wire logic stop_w = scl && scl_q_r && !sda_q_r && sda;
  wire logic rise_w = scl && !scl_q_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Line history; reset to the idle level so no false start appears.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl;
      sda_q_r <= sda;
    end
  end

  // Frame tracking; a repeated start restarts the count like a first start.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 4'h0;
      byte_r <= 4'h0;
      sh_r <= 8'h00;
      ign_r <= 1'b0;
      rd_r <= 1'b0;
    end else if (start_w) begin
      cnt_r <= 4'h0;
      byte_r <= 4'h0;
      ign_r <= 1'b0;
    end else if (rise_w) begin
      cnt_r <= (cnt_r == 4'h9) ? 4'h1 : cnt_r + 4'h1;
      if (cnt_r != 4'h8) begin
        sh_r <= {sh_r[6:0], sda};
      end
      if (cnt_r == 4'h8 && byte_r != 4'hf) begin
        byte_r <= byte_r + 4'h1;
      end
      if (cnt_r == 4'h8 && byte_r == 4'h0 && sh_r[7:1] != `TWS_SLAVE_ADDR) begin
        ign_r <= 1'b1;
      end
      // The direction bit is the last bit of the address byte.
      if (cnt_r == 4'h8 && byte_r == 4'h0) begin
        rd_r <= sh_r[0];
      end
    end
  end

  // The acknowledge pulse of any byte.
  sequence ninth_rise_s;
    rise_w && cnt_r == 4'h8;
  endsequence

  addr_ack_a: assert property (ninth_rise_s ##0 (byte_r == 4'h0
    && sh_r[7:1] == `TWS_SLAVE_ADDR) |-> sda_oe_s) else $error("address not acknowledged");
  addr_nak_a: assert property (ninth_rise_s ##0 (byte_r == 4'h0
    && sh_r[7:1] != `TWS_SLAVE_ADDR) |-> !sda_oe_s) else $error("foreign address acknowledged");
  addr_quiet_a: assert property (rise_w && byte_r == 4'h0 && cnt_r < 4'h8
    |-> !sda_oe_s) else $error("slave drove during address");
  wr_ack_a: assert property (ninth_rise_s ##0 byte_r == 4'h1 && !rd_r && !ign_r
    |-> sda_oe_s) else $error("pointer byte not acknowledged");
  ign_quiet_a: assert property (ign_r |-> !sda_oe_s) else $error("ignored slave drove");
  stop_rel_a: assert property (stop_w |-> !sda_oe_s) else $error("slave held data at stop");
  slv_stable_a: assert property (scl && scl_q_r |-> $stable(sda_oe_s))
    else $error("slave data moved while clock high");
  mst_stable_a: assert property (scl && scl_q_r && cnt_r >= 4'h2 |-> $stable(sda))
    else $error("data moved while clock high");
  // Master data may only move while it holds the clock low, apart from start and stop.
  mst_setup_a: assert property ($changed(sda_oe_m) && !start_w && !stop_w |-> scl_oe_m)
    else $error("master data moved outside clock low");
  mst_rel_a: assert property (ninth_rise_s ##0 (byte_r == 4'h0 || !rd_r) |-> !sda_oe_m)
    else $error("master held data in slave acknowledge slot");
endmodule // tws_monitor
`default_nettype wire

// [core/tws_consts.svh]
/*
  Constants for the two-wire slave with pointer and hysteresis register,
  and for the matching bus master end.
  Assumes inclusion by bare name from the modules and the bench.
*/
`ifndef TWS_CONSTS_SVH
`define TWS_CONSTS_SVH
`define TWS_SLAVE_ADDR 7'h4c
`define TWS_PTR_HYST 8'h21
`define TWS_HYST_RESET 8'h0a
`define TWS_PTR_RESET 8'h00
`define TWS_HS_CODE 5'h01
`define TWS_CLK_FREQ_HZ 100000000
`define TWS_LINK_FREQ_HZ 400000
`define TWS_HALF_CYCLES ((`TWS_CLK_FREQ_HZ / `TWS_LINK_FREQ_HZ) / 2)
`define TWS_ADDR_APB 12'h000
`define TWS_ADDR_WDATA 12'h004
`define TWS_ADDR_RDATA 12'h008
`define TWS_ADDR_STAT 12'h00c
`define TWS_CMD_GO_BIT 0
`define TWS_CMD_RD_BIT 1
`define TWS_CMD_PTRONLY_BIT 2
`endif

// [core/tws_if.sv]
/*
  Open-drain two-wire carrier joining master and slave.
  Assumes bench pull-ups: a line is low if any end enables its driver.
*/
`default_nettype none
interface tws_if;
  logic scl_oe_m; // Master pulls clock low.
  logic sda_oe_m; // Master pulls data low.
  logic sda_oe_s; // Slave pulls data low.
  logic scl; // Resolved clock level.
  logic sda; // Resolved data level.
  assign scl = ~scl_oe_m;
  assign sda = ~(sda_oe_m | sda_oe_s);
  modport master (output scl_oe_m, output sda_oe_m, input scl, input sda);
  modport slave (output sda_oe_s, input scl, input sda);
endinterface : tws_if
`default_nettype wire

// [core/tws_master.sv]
/*
  Two-wire master driven by APB registers: write pointer plus optional data
  byte, or read one byte from the current pointer.
  Assumes an APB master on the same clock and a slave on the bus carrier.
*/
// Decided for this implementation: the APB interface to the registers.
`include "tws_consts.svh"
`default_nettype none
module tws_master
  import tws_pkg::*;
#(
  parameter int HALF_CYCLES = `TWS_HALF_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  tws_if.master bus,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  logic [6:0] addr_r; // Target slave address.
  logic [7:0] ptr_r, wdat_r, rdat_r;
  logic do_rd_r, ptronly_r, busy_r, nack_r;
  logic [1:0] sda_sy_r; // Data synchroniser.
  logic [15:0] div_r; // Half-period divider.
  logic tick;
  tws_mst_st_t st_r;
  logic [2:0] phase_r; // Byte index within the transfer.
  logic [8:0] sh_r; // Outgoing bits.
  logic [3:0] bit_r;
  logic sub_r; // Low/high half of a bit.
  logic wr_go;

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr_go = psel & penable & pwrite & (paddr == `TWS_ADDR_APB) & ~busy_r
                 & pwdata[`TWS_CMD_GO_BIT];

  // Registers for command and write data.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_r <= `TWS_SLAVE_ADDR;
      ptr_r <= 8'h00;
      wdat_r <= 8'h00;
      do_rd_r <= 1'b0;
      ptronly_r <= 1'b0;
    end else if (psel && penable && pwrite && !busy_r) begin
      if (paddr == `TWS_ADDR_WDATA) begin
        wdat_r <= pwdata[7:0];
        ptr_r <= pwdata[15:8];
        addr_r <= pwdata[22:16];
      end else if (wr_go) begin
        do_rd_r <= pwdata[`TWS_CMD_RD_BIT];
        ptronly_r <= pwdata[`TWS_CMD_PTRONLY_BIT];
      end
    end
  end

  // Read mux; unmapped addresses read zero.
  always_comb begin
    prdata = 32'h0;
    case (paddr)
      `TWS_ADDR_WDATA: prdata = {9'h0, addr_r, ptr_r, wdat_r};
      `TWS_ADDR_RDATA: prdata = {24'h0, rdat_r};
      `TWS_ADDR_STAT: prdata = {30'h0, nack_r, busy_r};
      default: prdata = 32'h0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_sy_r <= 2'h3;
      div_r <= 16'h0;
    end else begin
      sda_sy_r <= {sda_sy_r[0], bus.sda};
      div_r <= (tick || st_r == TWS_M_IDLE) ? 16'h0 : div_r + 16'h1;
    end
  end
  assign tick = (div_r == 16'(HALF_CYCLES - 1));

  // Sequencer: phase 0 address write, 1 pointer, 2 data; 3 read address, 4 read data.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= TWS_M_IDLE;
      busy_r <= 1'b0;
      nack_r <= 1'b0;
      bus.scl_oe_m <= 1'b0;
      bus.sda_oe_m <= 1'b0;
      phase_r <= 3'h0;
      sh_r <= 9'h0;
      bit_r <= 4'h0;
      sub_r <= 1'b0;
      rdat_r <= 8'h00;
    end else begin
      case (st_r)
        TWS_M_IDLE: begin
          if (wr_go) begin
            busy_r <= 1'b1;
            nack_r <= 1'b0;
            phase_r <= 3'h0;
            st_r <= TWS_M_START;
          end
        end
        TWS_M_START, TWS_M_RSTART: begin
          if (tick) begin
            if (!sub_r) begin
              bus.sda_oe_m <= 1'b1; // Data falls with clock high.
              sub_r <= 1'b1;
            end else begin
              // Clock falls; the first address bit is set up while it is low.
              bus.scl_oe_m <= 1'b1;
              bus.sda_oe_m <= ~addr_r[6];
              sub_r <= 1'b0;
              sh_r <= {addr_r, do_rd_r, 1'b1};
              phase_r <= do_rd_r ? 3'h3 : 3'h0;
              bit_r <= 4'h0;
              st_r <= TWS_M_BIT;
            end
          end
        end
        TWS_M_BIT: begin
          // Nine bits, the last released for acknowledge. Data moves only with
          // the falling clock, so it is settled for the whole high half.
          if (tick) begin
            if (!sub_r) begin
              bus.scl_oe_m <= 1'b0;
              sub_r <= 1'b1;
            end else begin
              if (phase_r == 3'h4 && bit_r < 4'h8) begin
                rdat_r <= {rdat_r[6:0], sda_sy_r[1]};
              end
              if (bit_r == 4'h8 && phase_r != 3'h4) begin
                nack_r <= sda_sy_r[1];
              end
              bus.scl_oe_m <= 1'b1;
              bus.sda_oe_m <= ~sh_r[7];
              sub_r <= 1'b0;
              sh_r <= {sh_r[7:0], 1'b1};
              bit_r <= bit_r + 4'h1;
              if (bit_r == 4'h8) begin
                st_r <= TWS_M_ACK;
              end
            end
          end
        end
        TWS_M_ACK: begin
          // A pointer-only write stops right after the pointer byte.
          if (nack_r || phase_r == 3'h4 || phase_r == 3'h2
              || (phase_r == 3'h1 && ptronly_r)) begin
            st_r <= TWS_M_STOP;
          end else begin
            bit_r <= 4'h0;
            st_r <= TWS_M_BIT;
            case (phase_r)
              3'h0: begin
                phase_r <= 3'h1;
                sh_r <= {ptr_r, 1'b1};
                bus.sda_oe_m <= ~ptr_r[7];
              end
              3'h1: begin
                phase_r <= 3'h2;
                sh_r <= {wdat_r, 1'b1};
                bus.sda_oe_m <= ~wdat_r[7];
              end
              default: begin
                phase_r <= 3'h4;
                sh_r <= 9'h1ff; // Release; final bit nacks.
                bus.sda_oe_m <= 1'b0;
              end
            endcase
          end
        end
        TWS_M_STOP: begin
          if (tick) begin
            if (!sub_r) begin
              bus.sda_oe_m <= 1'b1;
              sub_r <= 1'b1;
            end else if (bus.scl_oe_m) begin
              bus.scl_oe_m <= 1'b0;
            end else begin
              bus.sda_oe_m <= 1'b0;
              sub_r <= 1'b0;
              st_r <= TWS_M_DONE;
            end
          end
        end
        TWS_M_DONE: begin
          busy_r <= 1'b0;
          st_r <= TWS_M_IDLE;
        end
        default: st_r <= TWS_M_IDLE;
      endcase
    end
  end
endmodule // tws_master
`default_nettype wire

// [core/tws_pkg.sv]
/*
  Types shared by both ends of the two-wire link.
  Assumes the constants header is on the include path.
*/
`default_nettype none
package tws_pkg;
  // Slave bit-level state, one-hot.
  typedef enum logic [5:0] {
    TWS_S_IDLE = 6'h01,
    TWS_S_RX = 6'h02,
    TWS_S_ACK = 6'h04,
    TWS_S_TX = 6'h08,
    TWS_S_TXACK = 6'h10,
    TWS_S_IGNORE = 6'h20
  } tws_slv_st_t;
  // Master sequencing state, one-hot.
  typedef enum logic [6:0] {
    TWS_M_IDLE = 7'h01,
    TWS_M_START = 7'h02,
    TWS_M_BIT = 7'h04,
    TWS_M_ACK = 7'h08,
    TWS_M_STOP = 7'h10,
    TWS_M_DONE = 7'h20,
    TWS_M_RSTART = 7'h40
  } tws_mst_st_t;
endpackage : tws_pkg
`default_nettype wire

// [core/tws_slave.sv]
/*
  Two-wire slave: start/stop detect, address match, pointer register and
  the eight-bit overtemperature hysteresis register.
  Assumes the bus lines are asynchronous and are synchronised here.
*/
`include "tws_consts.svh"
`default_nettype none
module tws_slave
  import tws_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = `TWS_SLAVE_ADDR
) (
  input wire logic clk,
  input wire logic rst_n,
  tws_if.slave bus,
  output logic [7:0] hyst_value_bits,
  output logic [7:0] ptr_value,
  output logic hs_mode
);
  logic [1:0] scl_sy_r; // Clock synchroniser.
  logic [1:0] sda_sy_r; // Data synchroniser.
  logic scl_d_r; // Previous synced clock.
  logic sda_d_r; // Previous synced data.
  logic scl_rise, scl_fall, start_det, stop_det;
  tws_slv_st_t st_r;
  logic [7:0] shift_r; // Receive/transmit shifter.
  logic [3:0] bit_cnt_r; // Bits moved in current byte.
  logic first_r; // Next byte is address byte.
  logic ptr_byte_r; // Next written byte is pointer.
  logic rd_r; // Current transfer is a read.
  logic ack_this_r; // Acknowledge the byte just taken.
  logic sda_oe_r; // Data pull-down.
  logic [7:0] rd_byte; // Register selected by pointer.

  // Two flops on each line before any decode.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sy_r <= 2'h3;
      sda_sy_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_sy_r <= {scl_sy_r[0], bus.scl};
      sda_sy_r <= {sda_sy_r[0], bus.sda};
      scl_d_r <= scl_sy_r[1];
      sda_d_r <= sda_sy_r[1];
    end
  end

  assign scl_rise = scl_sy_r[1] & ~scl_d_r;
  assign scl_fall = ~scl_sy_r[1] & scl_d_r;
  // Start and stop are data edges while clock stays high.
  assign start_det = scl_sy_r[1] & scl_d_r & sda_d_r & ~sda_sy_r[1];
  assign stop_det = scl_sy_r[1] & scl_d_r & ~sda_d_r & sda_sy_r[1];

  // Read mux; unmapped pointers read as zero.
  always_comb begin
    rd_byte = 8'h00;
    if (ptr_value == `TWS_PTR_HYST) begin
      rd_byte = hyst_value_bits;
    end
  end

  // Bit engine. The slave only follows the master clock; it never drives it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= TWS_S_IDLE;
      shift_r <= 8'h00;
      bit_cnt_r <= 4'h0;
      first_r <= 1'b0;
      ptr_byte_r <= 1'b0;
      rd_r <= 1'b0;
      ack_this_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (start_det) begin
      // Start or repeated start always resynchronises the engine.
      st_r <= TWS_S_RX;
      bit_cnt_r <= 4'h0;
      first_r <= 1'b1;
      sda_oe_r <= 1'b0;
    end else if (stop_det) begin
      st_r <= TWS_S_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      case (st_r)
        TWS_S_IDLE, TWS_S_IGNORE: begin
          // Released and deaf until the next start.
          sda_oe_r <= 1'b0;
        end
        TWS_S_RX: begin
          if (scl_rise) begin
            shift_r <= {shift_r[6:0], sda_sy_r[1]};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (scl_fall && bit_cnt_r == 4'h8) begin
            st_r <= TWS_S_ACK;
            bit_cnt_r <= 4'h0;
            if (first_r) begin
              first_r <= 1'b0;
              rd_r <= shift_r[0];
              ptr_byte_r <= ~shift_r[0];
              if (shift_r[7:1] == SLAVE_ADDR) begin
                sda_oe_r <= 1'b1;
                ack_this_r <= 1'b1;
              end else begin
                // High-speed code and foreign addresses are not acknowledged.
                sda_oe_r <= 1'b0;
                ack_this_r <= 1'b0;
              end
            end else begin
              sda_oe_r <= 1'b1;
              ack_this_r <= 1'b1;
              // Only the first written byte is the pointer; later ones are data.
              ptr_byte_r <= 1'b0;
            end
          end
        end
        TWS_S_ACK: begin
          // Leave the acknowledge slot on the falling edge of pulse nine.
          if (scl_fall) begin
            if (!ack_this_r) begin
              sda_oe_r <= 1'b0;
              st_r <= TWS_S_IGNORE;
            end else if (rd_r) begin
              shift_r <= {rd_byte[6:0], 1'b0};
              sda_oe_r <= ~rd_byte[7];
              st_r <= TWS_S_TX;
            end else begin
              sda_oe_r <= 1'b0;
              st_r <= TWS_S_RX;
            end
          end
        end
        TWS_S_TX: begin
          // Shift out after each falling edge, MSB first.
          if (scl_rise) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_r == 4'h8) begin
              sda_oe_r <= 1'b0;
              bit_cnt_r <= 4'h0;
              st_r <= TWS_S_TXACK;
            end else begin
              sda_oe_r <= ~shift_r[7];
              shift_r <= {shift_r[6:0], 1'b0};
            end
          end
        end
        TWS_S_TXACK: begin
          // Master ack asks for another byte; a nack ends our driving.
          if (scl_rise) begin
            ack_this_r <= ~sda_sy_r[1];
          end else if (scl_fall) begin
            if (ack_this_r) begin
              shift_r <= {rd_byte[6:0], 1'b0};
              sda_oe_r <= ~rd_byte[7];
              st_r <= TWS_S_TX;
            end else begin
              sda_oe_r <= 1'b0;
              st_r <= TWS_S_IGNORE;
            end
          end
        end
        default: begin
          st_r <= TWS_S_IDLE;
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  assign bus.sda_oe_s = sda_oe_r;

  // Pointer and hysteresis registers take a byte at its acknowledge.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_value <= `TWS_PTR_RESET;
      hyst_value_bits <= `TWS_HYST_RESET;
    end else if (st_r == TWS_S_RX && scl_fall && bit_cnt_r == 4'h8 && !first_r && !rd_r) begin
      if (ptr_byte_r) begin
        ptr_value <= shift_r;
      end else if (ptr_value == `TWS_PTR_HYST) begin
        hyst_value_bits <= shift_r;
      end
    end
  end

  // High-speed flag lives from the master code until the stop.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hs_mode <= 1'b0;
    end else if (stop_det) begin
      hs_mode <= 1'b0;
    end else if (st_r == TWS_S_RX && scl_fall && bit_cnt_r == 4'h8 && first_r
                 && shift_r[7:3] == `TWS_HS_CODE) begin
      hs_mode <= 1'b1;
    end
  end
endmodule // tws_slave
`default_nettype wire
